// ### hw/fpt_map.svh
`ifndef FPT_MAP_SVH
`define FPT_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define FPT_OFF_CTRL      8'h00
`define FPT_OFF_OF_FREQ   8'h04
`define FPT_OFF_UF_FREQ   8'h08
`define FPT_OFF_VOLT      8'h0C
`define FPT_OFF_RATE      8'h10
`define FPT_OFF_OF_DELAY  8'h14
`define FPT_OFF_UF_DELAY  8'h18
`define FPT_OFF_STATUS    8'h1C
`define FPT_OFF_IRQ_STAT  8'h20
`define FPT_OFF_IRQ_CLR   8'h24
`define FPT_OFF_IRQ_EN    8'h28

////////////////////////////////////////////////////////////////////////////////
// Control fields
`define FPT_CTRL_OF_EN     0
`define FPT_CTRL_UF_EN     1
`define FPT_CTRL_SINGLE_VT 2
`define FPT_CTRL_RESTRAIN  3
`define FPT_CTRL_BAND60    4
`define FPT_CTRL_W         5

// Interrupt bits
`define FPT_IRQ_OF_PICK    0
`define FPT_IRQ_OF_TRIP    1
`define FPT_IRQ_UF_PICK    2
`define FPT_IRQ_UF_TRIP    3
`define FPT_IRQ_W          4

////////////////////////////////////////////////////////////////////////////////
// Setting limits and reset values
`define FPT_OF_BASE50      16'h01F4
`define FPT_OF_BASE60      16'h0258
`define FPT_UF_BASE50      16'h0190
`define FPT_UF_BASE60      16'h01F4
`define FPT_OF_CODE_MAX    16'h0032
`define FPT_UF_CODE_MAX    16'h0064
`define FPT_VOLT_MIN       16'h0014
`define FPT_VOLT_MAX       16'h0032
`define FPT_RATE_MIN       16'h0001
`define FPT_RATE_MAX       16'h000F
`define FPT_DELAY_MIN      16'h000A
`define FPT_DELAY_MAX      16'h7530
`define FPT_HYST_CHZ       16'h0019
`define FPT_RST_CTRL       5'h00
`define FPT_RST_OF_CODE    6'h0A
`define FPT_RST_UF_CODE    7'h32
`define FPT_RST_VOLT       6'h14
`define FPT_RST_RATE       4'h5
`define FPT_RST_DELAY      15'h000A

////////////////////////////////////////////////////////////////////////////////
// Timing
`define FPT_CLK_PERIOD_NS  4
`define FPT_TICK_NS        10000000
`define FPT_TICK_CYCLES    (`FPT_TICK_NS / `FPT_CLK_PERIOD_NS)

`endif

// ### hw/fpt_pkg.sv
package fpt_pkg;

    typedef enum logic [1:0]
    {
        FPT_TMR_IDLE = 2'h0,
        FPT_TMR_RUN  = 2'h1,
        FPT_TMR_TRIP = 2'h3
    } fpt_tmr_state_t;

    typedef struct packed
    {
        fpt_tmr_state_t state;
        logic [14:0]    count;
    } fpt_tmr_regs_t;

    typedef struct packed
    {
        logic [21:0] count;
        logic        tick;
    } fpt_tick_regs_t;

    typedef struct packed
    {
        logic [4:0]  ctrl;
        logic [5:0]  of_code;
        logic [6:0]  uf_code;
        logic [5:0]  volt;
        logic [3:0]  rate;
        logic [14:0] of_delay;
        logic [14:0] uf_delay;
        logic [15:0] freq;
        logic [7:0]  vpos;
        logic [7:0]  vline;
        logic [15:0] freq_prev;
        logic        prev_ok;
        logic        restrained;
        logic        of_pick;
        logic        uf_pick;
        logic        of_trip_prev;
        logic        uf_trip_prev;
        logic [3:0]  irq_stat;
        logic [3:0]  irq_en;
        logic [31:0] rdata;
    } fpt_regs_t;

endpackage

// ### hw/fpt_tick_gen.sv
`timescale 1ns/1ns
`include "fpt_map.svh"

module fpt_tick_gen
#(
    parameter int unsigned TICK_CYCLES = `FPT_TICK_CYCLES
)
(
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    // Tick
    output logic      tick_out
);

    fpt_pkg::fpt_tick_regs_t r_q;
    fpt_pkg::fpt_tick_regs_t r_d;

    always_comb
    begin
        r_d      = r_q;
        r_d.tick = 1'b0;
        if (r_q.count == 22'(TICK_CYCLES - 1))
        begin
            r_d.count = 22'h0;
            r_d.tick  = 1'b1;
        end
        else
        begin
            r_d.count = r_q.count + 22'h1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign tick_out = r_q.tick;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    a_tick_single_pulse: assert property (tick_out |=> !tick_out)
        else $error("Tick longer than one cycle");

endmodule // fpt_tick_gen

// ### hw/fpt_delay_timer.sv
`timescale 1ns/1ns

module fpt_delay_timer
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // Control
    input  wire logic        tick_in,
    input  wire logic        arm_in,
    input  wire logic [14:0] delay_in,
    // Result
    output logic             trip_out
);

    fpt_pkg::fpt_tmr_regs_t r_q;
    fpt_pkg::fpt_tmr_regs_t r_d;
    logic [15:0]            next_cnt;

    assign next_cnt = {1'b0, r_q.count} + 16'h1;

    always_comb
    begin
        r_d = r_q;
        unique case (r_q.state)
            fpt_pkg::FPT_TMR_IDLE:
            begin
                r_d.count = 15'h0;
                if (arm_in)
                    r_d.state = fpt_pkg::FPT_TMR_RUN;
            end
            fpt_pkg::FPT_TMR_RUN:
            begin
                if (!arm_in)
                begin
                    r_d.state = fpt_pkg::FPT_TMR_IDLE;
                    r_d.count = 15'h0;
                end
                else if (tick_in)
                begin
                    r_d.count = next_cnt[14:0];
                    if (next_cnt >= {1'b0, delay_in})
                        r_d.state = fpt_pkg::FPT_TMR_TRIP;
                end
            end
            fpt_pkg::FPT_TMR_TRIP:
            begin
                if (!arm_in)
                begin
                    r_d.state = fpt_pkg::FPT_TMR_IDLE;
                    r_d.count = 15'h0;
                end
            end
            default:
            begin
                r_d.state = fpt_pkg::FPT_TMR_IDLE;
                r_d.count = 15'h0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign trip_out = (r_q.state == fpt_pkg::FPT_TMR_TRIP);

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    a_timer_clears_drop: assert property (!arm_in |=> !trip_out && r_q.count == 15'h0)
        else $error("Timer not cleared on drop-out");
    a_timer_trip_count: assert property ($rose(trip_out) |-> r_q.count >= delay_in)
        else $error("Trip before delay elapsed");
    a_timer_starts_zero: assert property ($rose(arm_in) |=> r_q.count == 15'h0)
        else $error("Timer did not start from zero");

endmodule // fpt_delay_timer

// ### hw/fpt_top.sv
`timescale 1ns/1ns
`include "fpt_map.svh"

module fpt_top
#(
    parameter int unsigned TICK_CYCLES = `FPT_TICK_CYCLES
)
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        reset_n_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Measurements
    input  wire logic        meas_valid_in,
    input  wire logic [15:0] meas_freq_in,
    input  wire logic [7:0]  meas_vpos_in,
    input  wire logic [7:0]  single_line_voltage_in,
    // Protection outputs
    output logic             of_pick_out,
    output logic             of_trip_out,
    output logic             uf_pick_out,
    output logic             uf_trip_out,
    output logic             uf_restrained_out,
    // Interrupt
    output logic             irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] fpt_clamp(input logic [15:0] v,
                                              input logic [15:0] lo,
                                              input logic [15:0] hi);
        if (v < lo)
            return lo;
        else if (v > hi)
            return hi;
        else
            return v;
    endfunction

    // Threshold in 0.01 Hz from a 0.1 Hz step code above the band base
    function automatic logic [15:0] fpt_thr(input logic [15:0] base,
                                            input logic [6:0]  code);
        logic [15:0] steps;
        steps = base + {9'h0, code};
        return 16'((steps << 3) + (steps << 1));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    fpt_pkg::fpt_regs_t r_q;
    fpt_pkg::fpt_regs_t r_d;

    logic        tick;
    logic        of_trip;
    logic        uf_trip;
    logic        band60;
    logic [15:0] of_thr;
    logic [15:0] uf_thr;
    logic [7:0]  volt_meas;
    logic        volt_ok;
    logic [15:0] fall;
    logic [3:0]  irq_set;
    logic [15:0] wlow;

    assign band60    = r_q.ctrl[`FPT_CTRL_BAND60];
    assign of_thr    = fpt_thr(band60 ? `FPT_OF_BASE60 : `FPT_OF_BASE50, {1'b0, r_q.of_code});
    assign uf_thr    = fpt_thr(band60 ? `FPT_UF_BASE60 : `FPT_UF_BASE50, r_q.uf_code);
    assign volt_meas = r_q.ctrl[`FPT_CTRL_SINGLE_VT] ? r_q.vline : r_q.vpos;
    assign volt_ok   = volt_meas > {2'h0, r_q.volt};
    assign fall      = (r_q.prev_ok && r_q.freq_prev > r_q.freq) ? 16'(r_q.freq_prev - r_q.freq)
                                                                 : 16'h0;
    assign wlow      = reg_wdata_in[15:0];

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        r_d = r_q;

        // Settings, clamped on write so the elements never see an illegal value
        if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                `FPT_OFF_CTRL:     r_d.ctrl     = reg_wdata_in[`FPT_CTRL_W-1:0];
                `FPT_OFF_OF_FREQ:  r_d.of_code  = 6'(fpt_clamp(wlow, 16'h0,
                                                               `FPT_OF_CODE_MAX));
                `FPT_OFF_UF_FREQ:  r_d.uf_code  = 7'(fpt_clamp(wlow, 16'h0,
                                                               `FPT_UF_CODE_MAX));
                `FPT_OFF_VOLT:     r_d.volt     = 6'(fpt_clamp(wlow, `FPT_VOLT_MIN,
                                                               `FPT_VOLT_MAX));
                `FPT_OFF_RATE:     r_d.rate     = 4'(fpt_clamp(wlow, `FPT_RATE_MIN,
                                                               `FPT_RATE_MAX));
                `FPT_OFF_OF_DELAY: r_d.of_delay = 15'(fpt_clamp(wlow, `FPT_DELAY_MIN,
                                                                `FPT_DELAY_MAX));
                `FPT_OFF_UF_DELAY: r_d.uf_delay = 15'(fpt_clamp(wlow, `FPT_DELAY_MIN,
                                                                `FPT_DELAY_MAX));
                `FPT_OFF_IRQ_EN:   r_d.irq_en   = reg_wdata_in[`FPT_IRQ_W-1:0];
                default:           r_d.irq_en   = r_q.irq_en;
            endcase
        end

        // Measurement capture
        if (meas_valid_in)
        begin
            r_d.freq  = meas_freq_in;
            r_d.vpos  = meas_vpos_in;
            r_d.vline = single_line_voltage_in;
        end

        // One 0.01 Hz fall per 10 ms is exactly 1 Hz/s
        if (tick)
        begin
            r_d.freq_prev  = r_q.freq;
            r_d.prev_ok    = 1'b1;
            r_d.restrained = r_q.ctrl[`FPT_CTRL_RESTRAIN]
                             && (fall > {12'h0, r_q.rate});
        end
        if (!r_q.ctrl[`FPT_CTRL_RESTRAIN])
            r_d.restrained = 1'b0;

        // Elements with hysteresis on the drop-out side
        r_d.of_pick = r_q.ctrl[`FPT_CTRL_OF_EN] && volt_ok
                      && (r_q.of_pick ? ({1'b0, r_q.freq} + {1'b0, `FPT_HYST_CHZ} > {1'b0, of_thr})
                                      : (r_q.freq > of_thr));
        r_d.uf_pick = r_q.ctrl[`FPT_CTRL_UF_EN] && volt_ok && !r_q.restrained
                      && (r_q.uf_pick ? ({1'b0, r_q.freq} < {1'b0, uf_thr} + {1'b0, `FPT_HYST_CHZ})
                                      : (r_q.freq < uf_thr));

        // Interrupts: a new event wins over a clear in the same cycle
        // Pick rises are taken from the next state so no event slips past a clear
        irq_set = {uf_trip & ~r_q.uf_trip_prev,
                   r_d.uf_pick & ~r_q.uf_pick,
                   of_trip & ~r_q.of_trip_prev,
                   r_d.of_pick & ~r_q.of_pick};
        r_d.of_trip_prev = of_trip;
        r_d.uf_trip_prev = uf_trip;
        r_d.irq_stat     = r_q.irq_stat;
        if (reg_wr_in && reg_addr_in == `FPT_OFF_IRQ_CLR)
            r_d.irq_stat = r_q.irq_stat & ~reg_wdata_in[`FPT_IRQ_W-1:0];
        r_d.irq_stat = r_d.irq_stat | irq_set;

        // Read data stand for one cycle only
        r_d.rdata = 32'h0;
        if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                `FPT_OFF_CTRL:     r_d.rdata = {27'h0, r_q.ctrl};
                `FPT_OFF_OF_FREQ:  r_d.rdata = {26'h0, r_q.of_code};
                `FPT_OFF_UF_FREQ:  r_d.rdata = {25'h0, r_q.uf_code};
                `FPT_OFF_VOLT:     r_d.rdata = {26'h0, r_q.volt};
                `FPT_OFF_RATE:     r_d.rdata = {28'h0, r_q.rate};
                `FPT_OFF_OF_DELAY: r_d.rdata = {17'h0, r_q.of_delay};
                `FPT_OFF_UF_DELAY: r_d.rdata = {17'h0, r_q.uf_delay};
                `FPT_OFF_STATUS:   r_d.rdata = {27'h0, r_q.restrained, uf_trip, r_q.uf_pick,
                                                of_trip, r_q.of_pick};
                `FPT_OFF_IRQ_STAT: r_d.rdata = {28'h0, r_q.irq_stat};
                `FPT_OFF_IRQ_EN:   r_d.rdata = {28'h0, r_q.irq_en};
                default:           r_d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_q          <= '0;
            r_q.ctrl     <= `FPT_RST_CTRL;
            r_q.of_code  <= `FPT_RST_OF_CODE;
            r_q.uf_code  <= `FPT_RST_UF_CODE;
            r_q.volt     <= `FPT_RST_VOLT;
            r_q.rate     <= `FPT_RST_RATE;
            r_q.of_delay <= `FPT_RST_DELAY;
            r_q.uf_delay <= `FPT_RST_DELAY;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tick and delay timers

    fpt_tick_gen
    #(
        .TICK_CYCLES (TICK_CYCLES)
    )
    u_tick
    (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n),
        .tick_out   (tick)
    );

    fpt_delay_timer u_of_timer
    (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n),
        .tick_in    (tick),
        .arm_in     (r_q.of_pick),
        .delay_in   (r_q.of_delay),
        .trip_out   (of_trip)
    );

    fpt_delay_timer u_uf_timer
    (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n),
        .tick_in    (tick),
        .arm_in     (r_q.uf_pick),
        .delay_in   (r_q.uf_delay),
        .trip_out   (uf_trip)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata_out     = r_q.rdata;
    assign of_pick_out       = r_q.of_pick;
    assign uf_pick_out       = r_q.uf_pick;
    assign of_trip_out       = of_trip;
    assign uf_trip_out       = uf_trip;
    assign uf_restrained_out = r_q.restrained;
    assign irq_out           = |(r_q.irq_stat & r_q.irq_en);

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n);

    a_of_pick_cause: assert property ((r_q.ctrl[`FPT_CTRL_OF_EN] && volt_ok
                                      && r_q.freq > of_thr) |=> of_pick_out)
        else $error("Overfrequency did not pick up");
    a_single_vt_volt: assert property ((r_q.ctrl[`FPT_CTRL_SINGLE_VT]
                                       && r_q.vline <= {2'h0, r_q.volt})
                                       |=> !of_pick_out && !uf_pick_out)
        else $error("Pick-up without line voltage");
    a_uf_pick_cause: assert property ((r_q.ctrl[`FPT_CTRL_UF_EN] && volt_ok && !r_q.restrained
                                      && r_q.freq < uf_thr) |=> uf_pick_out)
        else $error("Underfrequency did not pick up");
    a_settings_range: assert property (r_q.of_code <= 6'h32 && r_q.uf_code <= 7'h64
                                       && r_q.volt >= 6'h14 && r_q.volt <= 6'h32)
        else $error("Threshold setting out of range");
    a_of_hysteresis: assert property ((of_pick_out && r_q.ctrl[`FPT_CTRL_OF_EN] && volt_ok
                                      && r_q.freq + 16'h19 > of_thr) |=> of_pick_out)
        else $error("Overfrequency dropped inside hysteresis");
    a_of_dropout: assert property ((r_q.freq + 16'h19 <= of_thr) |=> !of_pick_out)
        else $error("Overfrequency held below drop-out");
    a_uf_hysteresis: assert property ((uf_pick_out && r_q.ctrl[`FPT_CTRL_UF_EN] && volt_ok
                                      && !r_q.restrained && r_q.freq < uf_thr + 16'h19)
                                      |=> uf_pick_out)
        else $error("Underfrequency dropped inside hysteresis");
    a_uf_dropout: assert property ((r_q.freq >= uf_thr + 16'h19) |=> !uf_pick_out)
        else $error("Underfrequency held above drop-out");
    a_restraint_blocks: assert property (uf_restrained_out |=> !uf_pick_out)
        else $error("Underfrequency picked up while restrained");
    a_restraint_off: assert property (!r_q.ctrl[`FPT_CTRL_RESTRAIN] |=> !uf_restrained_out)
        else $error("Restraint active while disabled");
    a_delay_range: assert property (r_q.of_delay >= 15'h000A && r_q.of_delay <= 15'h7530
                                    && r_q.uf_delay >= 15'h000A
                                    && r_q.uf_delay <= 15'h7530)
        else $error("Delay setting out of range");
    a_trip_needs_pick: assert property (of_trip_out |-> $past(of_pick_out))
        else $error("Trip without pick-up");
    a_read_one_cycle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("Read data held too long");

    c_of_trip:     cover property ($rose(of_trip_out));
    c_uf_trip:     cover property ($rose(uf_trip_out));
    c_restrained:  cover property ($rose(uf_restrained_out));
    c_irq:         cover property ($rose(irq_out));
    c_single_vt:   cover property (r_q.ctrl[`FPT_CTRL_SINGLE_VT] && $rose(of_pick_out));

endmodule // fpt_top

// ### test/fpt_meas_model.sv
`timescale 1ns/1ns

module fpt_meas_model
(
    // Clock
    input  wire logic        clk_sys_in,
    // Measurement strobe and values
    output logic             meas_valid_out,
    output logic      [15:0] meas_freq_out,
    output logic      [7:0]  meas_vpos_out,
    output logic      [7:0]  meas_vline_out
);
    logic [15:0] freq_q  = 16'h1388;
    logic [7:0]  vpos_q  = 8'h00;
    logic [7:0]  vline_q = 8'h00;
    logic [15:0] f_s     = 16'h1388;
    logic [7:0]  p_s     = 8'h00;
    logic [7:0]  l_s     = 8'h00;
    logic [1:0]  phase_q = 2'h0;

    // Called away from the rising edge; picked up at the next strobe
    task automatic set_meas(input logic [15:0] f, input logic [7:0] vp, input logic [7:0] vl);
        freq_q  = f;
        vpos_q  = vp;
        vline_q = vl;
    endtask

    always @(posedge clk_sys_in)
    begin
        phase_q <= phase_q + 2'h1;
        if (phase_q == 2'h3)
        begin
            f_s <= freq_q;
            p_s <= vpos_q;
            l_s <= vline_q;
        end
    end

    // Values only mean something with the strobe; between strobes they are scrambled
    assign meas_valid_out = (phase_q == 2'h0);
    assign meas_freq_out  = meas_valid_out ? f_s : ~f_s;
    assign meas_vpos_out  = meas_valid_out ? p_s : ~p_s;
    assign meas_vline_out = meas_valid_out ? l_s : ~l_s;
endmodule // fpt_meas_model

// ### test/test_frequency_protection_timer.sv
`timescale 1ns/1ns

module test_frequency_protection_timer;
    localparam int T = 10;
    logic        clk_sys   = 1'b0;
    logic        reset_n   = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] rdata;
    logic        mv;
    logic [15:0] mf;
    logic [7:0]  mp, ml;
    logic        of_pick, of_trip, uf_pick, uf_trip, uf_rst, irq;
    int          n_errors = 0;
    int          n_compared = 0;
    int          ctrl, of_thr, uf_thr, e_of, e_uf;
    logic [7:0]  ra [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
                             8'h28, 8'h30};
    logic [31:0] rv [11] = '{32'h0, 32'hA, 32'h32, 32'h14, 32'h5, 32'hA, 32'hA, 32'h0, 32'h0,
                             32'h0, 32'h0};

    fpt_top #(.TICK_CYCLES(T)) i_fpt_top
    (
        .clk_sys_in(clk_sys), .reset_n_in(reset_n), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata), .meas_valid_in(mv), .meas_freq_in(mf), .meas_vpos_in(mp),
        .single_line_voltage_in(ml), .of_pick_out(of_pick), .of_trip_out(of_trip),
        .uf_pick_out(uf_pick), .uf_trip_out(uf_trip), .uf_restrained_out(uf_rst),
        .irq_out(irq)
    );

    fpt_meas_model i_fpt_meas_model
    (
        .clk_sys_in(clk_sys), .meas_valid_out(mv), .meas_freq_out(mf),
        .meas_vpos_out(mp), .meas_vline_out(ml)
    );

    ////////////////////////////////////////////////////////////
    initial
        forever #2 clk_sys = ~clk_sys;

    task automatic report_and_stop;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        check(rdata, e);
    endtask

    // Model thresholds in 0.01 Hz; voltage threshold fixed at 30 %
    task automatic cfg(input int c, input int oc, input int uc, input int dly);
        ctrl   = c;
        of_thr = (c[4] ? 6000 : 5000) + 10 * oc;
        uf_thr = (c[4] ? 5000 : 4000) + 10 * uc;
        wr(8'h04, oc);
        wr(8'h08, uc);
        wr(8'h0C, 32'h1E);
        wr(8'h14, dly);
        wr(8'h18, dly);
        wr(8'h00, c);
    endtask

    // Pick state follows the hysteresis band, so history matters
    task automatic set_m(input int f, input int vp, input int vl);
        int v;
        v = ctrl[2] ? vl : vp;
        e_of = ctrl[0] && v > 30 && (f > of_thr || (e_of != 0 && f > of_thr - 25));
        e_uf = ctrl[1] && v > 30 && (f < uf_thr || (e_uf != 0 && f < uf_thr + 25));
        @(negedge clk_sys);
        i_fpt_meas_model.set_meas(16'(f), 8'(vp), 8'(vl));
        repeat (12) @(posedge clk_sys);
        #1;
        check(of_pick, e_of[0]);
        check(uf_pick, e_uf[0]);
    endtask

    // Trip time counted from the pick check; timer start leads it by a few cycles
    task automatic tripw(input logic uf, input int d);
        int n;
        n = 0;
        while ((uf ? uf_trip : of_trip) !== 1'b1 && n < 400)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check(n >= (d - 1) * T - 10 && n <= d * T + 4, 1'b1);
    endtask

    task automatic ramp;
        for (int k = 0; k < 40; k++)
        begin
            @(negedge clk_sys);
            i_fpt_meas_model.set_meas(16'(4700 - 12 * k), 8'h28, 8'h28);
            repeat (4) @(posedge clk_sys);
        end
        #1;
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(34));
        e_of = 0;
        e_uf = 0;
        ctrl = 0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 11; i++)
            rd(ra[i], rv[i]);
        wr(8'h04, 32'h3F);
        rd(8'h04, 32'h32);
        wr(8'h0C, 32'h05);
        rd(8'h0C, 32'h14);
        wr(8'h18, 32'h8000);
        rd(8'h18, 32'h7530);
        wr(8'h10, 32'h0);
        rd(8'h10, 32'h1);
        cfg(3, 10, 50, 12);
        wr(8'h28, 32'hF);
        set_m(5000, 40, 0);
        set_m(5101, 30, 0);
        set_m(5101, 31, 0);
        tripw(0, 12);
        check(irq, 1'b1);
        rd(8'h20, 32'h3);
        rd(8'h1C, 32'h3);
        set_m(5080, 31, 0);
        set_m(5070, 31, 0);
        check(of_trip, 1'b0);
        wr(8'h24, 32'hF);
        rd(8'h20, 32'h0);
        check(irq, 1'b0);
        set_m(5200, 40, 0);
        repeat (60) @(posedge clk_sys);
        set_m(5000, 40, 0);
        check(of_trip, 1'b0);
        wr(8'h28, 32'h0);
        set_m(5200, 40, 0);
        tripw(0, 12);
        check(irq, 1'b0);
        rd(8'h20, 32'h3);
        wr(8'h24, 32'hF);
        cfg(7, 10, 50, 12);
        set_m(5200, 0, 40);
        set_m(5200, 40, 10);
        set_m(4499, 40, 40);
        tripw(1, 12);
        rd(8'h20, 32'hD);
        set_m(4520, 40, 40);
        set_m(4530, 40, 40);
        cfg(19, 50, 100, 12);
        set_m(6501, 40, 0);
        set_m(6400, 40, 0);
        set_m(5999, 40, 0);
        cfg(19, 50, 100, 30000);
        repeat (150)
            set_m($urandom_range(6600, 5900), $urandom_range(35, 25), 0);
        check(of_trip | uf_trip, 1'b0);
        cfg(10, 10, 50, 30000);
        wr(8'h10, 32'h5);
        ramp();
        check({uf_rst, uf_pick}, 2'h2);
        // Restraint only lets go one tick after the fall has stopped
        i_fpt_meas_model.set_meas(16'h107C, 8'h28, 8'h00);
        repeat (30) @(posedge clk_sys);
        set_m(4220, 40, 0);
        check(uf_rst, 1'b0);
        wr(8'h00, 32'h2);
        ctrl = 2;
        ramp();
        check({uf_rst, uf_pick}, 2'h1);
        report_and_stop();
    end

    initial
    begin
        #200000;
        n_errors++;
        report_and_stop();
    end
endmodule // test_frequency_protection_timer
